// ===== gdcr_defs.vh
// Contract
// - input mode: 00 six,01 three,10 single,11 independent
// - bit 9 set disables pump undervoltage fault
// - bit 8 set disables gate drive fault
// - bit 7 routes overtemp warning to fault
// - bit 4 selects diode freewheeling in single mode
// - single mode direction is bit 3 OR pin
// - bit 2 turns all six switches off
// - single mode brake bit OR pin: lows on
// - bit 0 write clears faults, self clears
// - lock key 110 blocks most writes
// - only 011 unlocks; lock resets to 011
// - high side strength codes reset to 1111
// - low side strength codes reset to 1111
// - low side bit 10 set, retry mode: pwm edge clears overcurrent fault
// - drive time 500/1000/2000/4000 ns, reset 11
// - retry interval 4 ms or 50 us
// - dead time 50/100/200/400 ns, reset 01
// - overcurrent response codes, reset 01 retry
// - deglitch 2/4/6/8 us, reset 01
// - drain-source threshold resets to 1001
// - summary fault ORs faults, matches pin
`ifndef GDCR_DEFS_VH
`define GDCR_DEFS_VH

// register indices; byte address is four times these
`define GDCR_IDX_DRV 4'h2
`define GDCR_IDX_HS 4'h3
`define GDCR_IDX_LS 4'h4
`define GDCR_IDX_OCP 4'h5
`define GDCR_IDX_STAT 4'h8

// reset values
`define GDCR_DRV_RST 11'h000
`define GDCR_HS_RST 11'h3ff
`define GDCR_LS_RST 11'h7ff
`define GDCR_OCP_RST 11'h159

// field positions
`define GDCR_DRV_CLR 0
`define GDCR_DRV_BRAKE 1
`define GDCR_DRV_COAST 2
`define GDCR_DRV_DIR 3
`define GDCR_DRV_FREE 4
`define GDCR_DRV_MODE 6:5
`define GDCR_DRV_OTW 7
`define GDCR_DRV_GDF 8
`define GDCR_DRV_CPUV 9
`define GDCR_HS_LOCK 10:8
`define GDCR_SRC 7:4
`define GDCR_SNK 3:0
`define GDCR_LS_CBC 10
`define GDCR_LS_TDRV 9:8
`define GDCR_OCP_RETRY_INTERVAL 10
`define GDCR_OCP_DEAD 9:8
`define GDCR_OVERCURRENT_RESPONSE 7:6
`define GDCR_OVERCURRENT_DEGLITCH 5:4
`define GDCR_OCP_VDS 3:0

// codes
`define GDCR_LOCK_KEY 3'h6
`define GDCR_UNLOCK_KEY 3'h3
`define GDCR_MODE_SIX 2'h0
`define GDCR_MODE_THREE 2'h1
`define GDCR_MODE_SINGLE 2'h2
`define GDCR_MODE_INDEP 2'h3
`define GDCR_OC_LATCH 2'h0
`define GDCR_OC_RETRY 2'h1
`define GDCR_OC_REPORT 2'h2
`define GDCR_OC_OFF 2'h3

// timing, clock period 8 ns; least times round up
`define GDCR_CLK_NS 8
`define GDCR_DEAD_NS0 50
`define GDCR_DEAD_NS1 100
`define GDCR_DEAD_NS2 200
`define GDCR_DEAD_NS3 400
`define GDCR_TDRV_NS0 500
`define GDCR_TDRV_NS1 1000
`define GDCR_TDRV_NS2 2000
`define GDCR_TDRV_NS3 4000
`define GDCR_DEG_US0 2
`define GDCR_DEG_US1 4
`define GDCR_DEG_US2 6
`define GDCR_DEG_US3 8
`define GDCR_RETRY_LONG_US 4000
`define GDCR_RETRY_SHORT_US 50
`define GDCR_RETRY_LONG_CYC 19'h7a120
`define GDCR_RETRY_SHORT_CYC 19'h0186a
`define GDCR_NS2CYC(t) (((t) + `GDCR_CLK_NS - 1) / `GDCR_CLK_NS)
`define GDCR_US2CYC(t) `GDCR_NS2CYC((t) * 1000)

`endif

// ===== gdcr_regs.v
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gdcr_defs.vh"

module gdcr_regs #(
   parameter [18:0] RETRY_LONG_CYC = `GDCR_RETRY_LONG_CYC,
   parameter [18:0] RETRY_SHORT_CYC = `GDCR_RETRY_SHORT_CYC
) (
   // clock and reset
   input wire MCLK,
   input wire NRST,
   // avalon-mm slave
   input wire [5:0] ADDRESS,
   input wire READ,
   input wire WRITE,
   input wire [3:0] BYTEENABLE,
   input wire [31:0] WRITEDATA,
   output wire [31:0] READDATA,
   output wire WAITREQUEST,
   // pins
   input wire DIRECTION_INPUT_PIN,
   input wire BRAKE_INPUT_PIN,
   input wire PWM_INPUT_PIN,
   output wire FAULT_OUTPUT_PIN_N,
   // protection logic
   input wire LATCHED_FAULTS,
   input wire OVERTEMP_WARNING,
   output wire FAULT_CLEAR,
   output wire CYCLE_FAULT_CLEAR,
   output wire SUMMARY_FAULT,
   output wire PUMP_UNDERVOLT_DISABLE,
   output wire GATE_FAULT_DISABLE,
   output wire [1:0] OVERCURRENT_RESPONSE,
   output wire [9:0] DEGLITCH_CYC,
   output wire [18:0] RETRY_CYC,
   output wire [3:0] DRAIN_SOURCE_THRESHOLD,
   // pwm decode and gate drive
   output wire [1:0] INPUT_MODE,
   output wire SINGLE_INPUT_FREEWHEEL,
   output wire SINGLE_INPUT_DIRECTION,
   output wire BRAKE_ALL_LOW,
   output wire COAST_ALL_OFF,
   output wire [3:0] HIGH_SOURCE_STRENGTH,
   output wire [3:0] HIGH_SINK_STRENGTH,
   output wire [3:0] LOW_SOURCE_STRENGTH,
   output wire [3:0] LOW_SINK_STRENGTH,
   output wire [8:0] PEAK_DRIVE_CYC,
   output wire [5:0] DEAD_CYC
);

   ////////////////////////////////////////////////////////////////////
   // declarations

   reg [10:0] drv_r;
   reg [10:0] hs_r;
   reg [10:0] ls_r;
   reg [10:0] ocp_r;
   reg [10:0] drv_nxt;
   reg [10:0] hs_nxt;
   reg [10:0] ls_nxt;
   reg [10:0] ocp_nxt;
   reg clr_r;
   reg ack_r;
   reg [31:0] rdata_r;
   reg [31:0] rdata_nxt;
   wire dir_sync;
   wire brk_sync;
   wire pwm_sync;
   reg pwm_prev_r;
   reg cyc_clr_r;
   reg fault_r;
   reg dir_r;
   reg brake_r;
   reg [9:0] deg_r;
   reg [18:0] retry_r;
   reg [8:0] tdrv_r;
   reg [5:0] dead_r;
   reg [9:0] deg_nxt;
   reg [18:0] retry_nxt;
   reg [8:0] tdrv_nxt;
   reg [5:0] dead_nxt;
   reg [10:0] wmerge;
   wire [3:0] idx;
   wire req;
   wire wr_go;
   wire locked;
   wire single;
   wire dir_eff;
   wire brake_eff;
   wire fault_nxt;
   wire [10:0] stat;

   ////////////////////////////////////////////////////////////////////
   // avalon handshake: one wait cycle, then answer

   assign idx = ADDRESS[5:2];
   assign req = READ | WRITE;
   assign WAITREQUEST = req & ~ack_r;
   assign wr_go = WRITE & ack_r;

   always @(posedge MCLK) begin
      if (!NRST) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // byte-lane merge of write data into the addressed register

   always @* begin
      case (idx)
         `GDCR_IDX_DRV: wmerge = drv_r;
         `GDCR_IDX_HS: wmerge = hs_r;
         `GDCR_IDX_LS: wmerge = ls_r;
         `GDCR_IDX_OCP: wmerge = ocp_r;
         default: wmerge = 11'h000;
      endcase
      if (BYTEENABLE[0]) begin
         wmerge[7:0] = WRITEDATA[7:0];
      end
      if (BYTEENABLE[1]) begin
         wmerge[10:8] = WRITEDATA[10:8];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register updates with lock

   assign locked = (hs_r[`GDCR_HS_LOCK] == `GDCR_LOCK_KEY);

   always @* begin
      drv_nxt = drv_r;
      hs_nxt = hs_r;
      ls_nxt = ls_r;
      ocp_nxt = ocp_r;
      if (wr_go) begin
         case (idx)
            `GDCR_IDX_DRV: begin
               if (locked) begin
                  drv_nxt[2:0] = wmerge[2:0];
               end else begin
                  drv_nxt = wmerge;
               end
            end
            `GDCR_IDX_HS: begin
               if (locked) begin
                  if (wmerge[`GDCR_HS_LOCK] == `GDCR_UNLOCK_KEY) begin
                     hs_nxt[`GDCR_HS_LOCK] = `GDCR_UNLOCK_KEY;
                  end
               end else begin
                  hs_nxt[7:0] = wmerge[7:0];
                  if (wmerge[`GDCR_HS_LOCK] == `GDCR_LOCK_KEY) begin
                     hs_nxt[`GDCR_HS_LOCK] = `GDCR_LOCK_KEY;
                  end
               end
            end
            `GDCR_IDX_LS: begin
               if (!locked) begin
                  ls_nxt = wmerge;
               end
            end
            `GDCR_IDX_OCP: begin
               if (!locked) begin
                  ocp_nxt = wmerge;
               end
            end
            default: begin
               drv_nxt = drv_r;
            end
         endcase
      end
      // fault clear never holds, not even after its own write; reads back zero
      drv_nxt[`GDCR_DRV_CLR] = 1'b0;
   end

   always @(posedge MCLK) begin
      if (!NRST) begin
         drv_r <= `GDCR_DRV_RST;
         hs_r <= `GDCR_HS_RST;
         ls_r <= `GDCR_LS_RST;
         ocp_r <= `GDCR_OCP_RST;
         clr_r <= 1'b0;
      end else begin
         drv_r <= drv_nxt;
         hs_r <= hs_nxt;
         ls_r <= ls_nxt;
         ocp_r <= ocp_nxt;
         // one-cycle clear pulse, also taken while locked
         clr_r <= wr_go & (idx == `GDCR_IDX_DRV) & wmerge[`GDCR_DRV_CLR];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read path, captured in the wait cycle

   assign stat = {6'h00, drv_r[`GDCR_DRV_COAST], brake_r, dir_r, locked, fault_r};

   always @* begin
      case (idx)
         `GDCR_IDX_DRV: rdata_nxt = {21'h000000, drv_r};
         `GDCR_IDX_HS: rdata_nxt = {21'h000000, hs_r};
         `GDCR_IDX_LS: rdata_nxt = {21'h000000, ls_r};
         `GDCR_IDX_OCP: rdata_nxt = {21'h000000, ocp_r};
         `GDCR_IDX_STAT: rdata_nxt = {21'h000000, stat};
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   always @(posedge MCLK) begin
      if (!NRST) begin
         rdata_r <= 32'h00000000;
      end else if (READ & ~ack_r) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign READDATA = rdata_r;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers

   gdcr_sync #(.rst_val(1'b0)) u_dir_sync (
      .clk(MCLK), .rst_n(NRST), .pin(DIRECTION_INPUT_PIN), .pin_sync(dir_sync)
   );
   gdcr_sync #(.rst_val(1'b0)) u_brk_sync (
      .clk(MCLK), .rst_n(NRST), .pin(BRAKE_INPUT_PIN), .pin_sync(brk_sync)
   );
   gdcr_sync #(.rst_val(1'b0)) u_pwm_sync (
      .clk(MCLK), .rst_n(NRST), .pin(PWM_INPUT_PIN), .pin_sync(pwm_sync)
   );

   // previous pwm level, reset to the idle low so no false edge follows reset
   always @(posedge MCLK) begin
      if (!NRST) begin
         pwm_prev_r <= 1'b0;
      end else begin
         pwm_prev_r <= pwm_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // decode and protection outputs

   assign single = (drv_r[`GDCR_DRV_MODE] == `GDCR_MODE_SINGLE);
   assign dir_eff = drv_r[`GDCR_DRV_DIR] | dir_sync;
   assign brake_eff = single & (drv_r[`GDCR_DRV_BRAKE] | brk_sync);
   assign fault_nxt = LATCHED_FAULTS | (drv_r[`GDCR_DRV_OTW] & OVERTEMP_WARNING);

   always @(posedge MCLK) begin
      if (!NRST) begin
         fault_r <= 1'b0;
         dir_r <= 1'b0;
         brake_r <= 1'b0;
         cyc_clr_r <= 1'b0;
      end else begin
         // one flop feeds both pin and bit so they never differ
         fault_r <= fault_nxt;
         dir_r <= dir_eff;
         brake_r <= brake_eff;
         cyc_clr_r <= ls_r[`GDCR_LS_CBC] & (ocp_r[`GDCR_OVERCURRENT_RESPONSE] == `GDCR_OC_RETRY)
                      & (pwm_sync ^ pwm_prev_r);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // timing code to cycle count

   // counts come out 32 bits wide; cut to the output widths on purpose
   localparam [31:0] deg_w0 = `GDCR_US2CYC(`GDCR_DEG_US0);
   localparam [31:0] deg_w1 = `GDCR_US2CYC(`GDCR_DEG_US1);
   localparam [31:0] deg_w2 = `GDCR_US2CYC(`GDCR_DEG_US2);
   localparam [31:0] deg_w3 = `GDCR_US2CYC(`GDCR_DEG_US3);
   localparam [31:0] tdrv_w0 = `GDCR_NS2CYC(`GDCR_TDRV_NS0);
   localparam [31:0] tdrv_w1 = `GDCR_NS2CYC(`GDCR_TDRV_NS1);
   localparam [31:0] tdrv_w2 = `GDCR_NS2CYC(`GDCR_TDRV_NS2);
   localparam [31:0] tdrv_w3 = `GDCR_NS2CYC(`GDCR_TDRV_NS3);
   localparam [31:0] dead_w0 = `GDCR_NS2CYC(`GDCR_DEAD_NS0);
   localparam [31:0] dead_w1 = `GDCR_NS2CYC(`GDCR_DEAD_NS1);
   localparam [31:0] dead_w2 = `GDCR_NS2CYC(`GDCR_DEAD_NS2);
   localparam [31:0] dead_w3 = `GDCR_NS2CYC(`GDCR_DEAD_NS3);

   always @* begin
      case (ocp_r[`GDCR_OVERCURRENT_DEGLITCH])
         2'h0: deg_nxt = deg_w0[9:0];
         2'h1: deg_nxt = deg_w1[9:0];
         2'h2: deg_nxt = deg_w2[9:0];
         default: deg_nxt = deg_w3[9:0];
      endcase
      if (ocp_r[`GDCR_OCP_RETRY_INTERVAL]) begin
         retry_nxt = RETRY_SHORT_CYC;
      end else begin
         retry_nxt = RETRY_LONG_CYC;
      end
      case (ls_r[`GDCR_LS_TDRV])
         2'h0: tdrv_nxt = tdrv_w0[8:0];
         2'h1: tdrv_nxt = tdrv_w1[8:0];
         2'h2: tdrv_nxt = tdrv_w2[8:0];
         default: tdrv_nxt = tdrv_w3[8:0];
      endcase
      case (ocp_r[`GDCR_OCP_DEAD])
         2'h0: dead_nxt = dead_w0[5:0];
         2'h1: dead_nxt = dead_w1[5:0];
         2'h2: dead_nxt = dead_w2[5:0];
         default: dead_nxt = dead_w3[5:0];
      endcase
   end

   always @(posedge MCLK) begin
      if (!NRST) begin
         deg_r <= 10'h000;
         retry_r <= 19'h00000;
         tdrv_r <= 9'h000;
         dead_r <= 6'h00;
      end else begin
         deg_r <= deg_nxt;
         retry_r <= retry_nxt;
         tdrv_r <= tdrv_nxt;
         dead_r <= dead_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output assignments

   assign FAULT_OUTPUT_PIN_N = ~fault_r;
   assign SUMMARY_FAULT = fault_r;
   assign FAULT_CLEAR = clr_r;
   assign CYCLE_FAULT_CLEAR = cyc_clr_r;
   assign PUMP_UNDERVOLT_DISABLE = drv_r[`GDCR_DRV_CPUV];
   assign GATE_FAULT_DISABLE = drv_r[`GDCR_DRV_GDF];
   assign OVERCURRENT_RESPONSE = ocp_r[`GDCR_OVERCURRENT_RESPONSE];
   assign DEGLITCH_CYC = deg_r;
   assign RETRY_CYC = retry_r;
   assign DRAIN_SOURCE_THRESHOLD = ocp_r[`GDCR_OCP_VDS];
   assign INPUT_MODE = drv_r[`GDCR_DRV_MODE];
   assign SINGLE_INPUT_FREEWHEEL = single & drv_r[`GDCR_DRV_FREE];
   assign SINGLE_INPUT_DIRECTION = dir_r;
   assign BRAKE_ALL_LOW = brake_r;
   assign COAST_ALL_OFF = drv_r[`GDCR_DRV_COAST];
   assign HIGH_SOURCE_STRENGTH = hs_r[`GDCR_SRC];
   assign HIGH_SINK_STRENGTH = hs_r[`GDCR_SNK];
   assign LOW_SOURCE_STRENGTH = ls_r[`GDCR_SRC];
   assign LOW_SINK_STRENGTH = ls_r[`GDCR_SNK];
   assign PEAK_DRIVE_CYC = tdrv_r;
   assign DEAD_CYC = dead_r;

endmodule // gdcr_regs

////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for one pin

module gdcr_sync #(
   parameter [0:0] rst_val = 1'b0
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // pin and its synchronised copy
   input wire pin,
   output wire pin_sync
);

   reg [1:0] sync_r;

   always @(posedge clk) begin
      if (!rst_n) begin
         sync_r <= {2{rst_val}};
      end else begin
         sync_r <= {sync_r[0], pin};
      end
   end

   // only the second flop leaves the module
   assign pin_sync = sync_r[1];

endmodule // gdcr_sync

`default_nettype wire

// ===== gdcr_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module gdcr_chk (
   // clock and reset
   input wire MCLK,
   input wire NRST,
   // register bus
   input wire WRITE,
   input wire WAITREQUEST,
   input wire [5:0] ADDRESS,
   input wire [31:0] WRITEDATA,
   input wire [3:0] BYTEENABLE,
   // fault path
   input wire FAULT_CLEAR,
   input wire SUMMARY_FAULT,
   input wire FAULT_OUTPUT_PIN_N,
   input wire LATCHED_FAULTS,
   input wire OVERTEMP_WARNING,
   // drive settings
   input wire [1:0] INPUT_MODE,
   input wire COAST_ALL_OFF,
   input wire SINGLE_INPUT_FREEWHEEL,
   input wire [5:0] DEAD_CYC,
   input wire [8:0] PEAK_DRIVE_CYC
);
   wire wr_drv = WRITE && !WAITREQUEST && ADDRESS[5:2] == 4'h2;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   ////////////////////////////////////////////////////////////
   a_pin_mirror: assert property (FAULT_OUTPUT_PIN_N == !SUMMARY_FAULT)
      else $error("fault pin differs from summary");
   a_fault_set: assert property (LATCHED_FAULTS |=> SUMMARY_FAULT)
      else $error("latched fault not summarised");
   a_fault_quiet: assert property (!LATCHED_FAULTS && !OVERTEMP_WARNING |=> !SUMMARY_FAULT)
      else $error("summary fault without cause");
   a_one_wait: assert property (WRITE && WAITREQUEST |=> !WAITREQUEST)
      else $error("write waited more than one cycle");
   a_clear_pulse: assert property (wr_drv && BYTEENABLE[0] && WRITEDATA[0] |=> FAULT_CLEAR ##1 !FAULT_CLEAR)
      else $error("fault clear pulse wrong");
   a_clear_cause: assert property (FAULT_CLEAR |-> $past(wr_drv))
      else $error("fault clear without write");
   a_free_mode: assert property (SINGLE_INPUT_FREEWHEEL |-> INPUT_MODE == 2'h2)
      else $error("freewheel outside single mode");
   a_mode_hold: assert property ($changed({INPUT_MODE, COAST_ALL_OFF}) |-> $past(wr_drv))
      else $error("mode or coast moved without write");
   a_dead_legal: assert property (NRST && $past(NRST) |-> DEAD_CYC inside {6'd7, 6'd13, 6'd25, 6'd50})
      else $error("dead time count illegal");
   a_peak_legal: assert property (NRST && $past(NRST) |-> PEAK_DRIVE_CYC inside {9'd63, 9'd125, 9'd250, 9'd500})
      else $error("peak drive count illegal");
endmodule // gdcr_chk
bind gdcr_regs gdcr_chk u_gdcr_chk (.MCLK, .NRST, .WRITE, .WAITREQUEST, .ADDRESS, .WRITEDATA, .BYTEENABLE,
   .FAULT_CLEAR, .SUMMARY_FAULT, .FAULT_OUTPUT_PIN_N, .LATCHED_FAULTS, .OVERTEMP_WARNING, .INPUT_MODE,
   .COAST_ALL_OFF, .SINGLE_INPUT_FREEWHEEL, .DEAD_CYC, .PEAK_DRIVE_CYC);
`default_nettype wire

// ===== gdcr_prot_model.sv
`timescale 1ns/1ps
`default_nettype none
module gdcr_prot_model (
   // clock and reset
   input wire MCLK,
   input wire NRST,
   // fault event and clears
   input wire trip,
   input wire FAULT_CLEAR,
   input wire CYCLE_FAULT_CLEAR,
   output var logic LATCHED_FAULTS
);
   // a clear wins over a fresh trip
   always @(posedge MCLK) begin
      if (!NRST || FAULT_CLEAR || CYCLE_FAULT_CLEAR)
         LATCHED_FAULTS <= 1'b0;
      else if (trip)
         LATCHED_FAULTS <= 1'b1;
   end
endmodule // gdcr_prot_model
`default_nettype wire

// ===== gdcr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gdcr_regs_tb;
   logic clk = 0, nrst = 0, rd = 0, wr = 0, dir = 0, brk = 0, pwm = 0, overtemp_warning = 0, trip = 0;
   logic [5:0] adr = 0;
   logic [3:0] be = 0;
   logic [31:0] wdat = 0, rdat, q;
   logic wreq, nflt, fclr, cclr, sflt, lat, pud, gfd, sdir, bral, coast, free;
   logic [1:0] ocm, mode, ln;
   logic [9:0] deg;
   logic [18:0] rty;
   logic [3:0] vds, hsp, hsn, lsp, lsn;
   logic [8:0] peak;
   logic [5:0] dead;
   logic [10:0] r, ex;
   int err_total = 0, cmp_count = 0, n;
   gdcr_regs #(.RETRY_LONG_CYC(19'd40), .RETRY_SHORT_CYC(19'd10)) u_gdcr_regs (
      .MCLK(clk), .NRST(nrst), .ADDRESS(adr), .READ(rd), .WRITE(wr), .BYTEENABLE(be), .WRITEDATA(wdat),
      .READDATA(rdat), .WAITREQUEST(wreq), .DIRECTION_INPUT_PIN(dir), .BRAKE_INPUT_PIN(brk),
      .PWM_INPUT_PIN(pwm), .FAULT_OUTPUT_PIN_N(nflt), .LATCHED_FAULTS(lat), .OVERTEMP_WARNING(overtemp_warning),
      .FAULT_CLEAR(fclr), .CYCLE_FAULT_CLEAR(cclr), .SUMMARY_FAULT(sflt), .PUMP_UNDERVOLT_DISABLE(pud),
      .GATE_FAULT_DISABLE(gfd), .OVERCURRENT_RESPONSE(ocm), .DEGLITCH_CYC(deg), .RETRY_CYC(rty),
      .DRAIN_SOURCE_THRESHOLD(vds), .INPUT_MODE(mode), .SINGLE_INPUT_FREEWHEEL(free),
      .SINGLE_INPUT_DIRECTION(sdir), .BRAKE_ALL_LOW(bral), .COAST_ALL_OFF(coast),
      .HIGH_SOURCE_STRENGTH(hsp), .HIGH_SINK_STRENGTH(hsn), .LOW_SOURCE_STRENGTH(lsp),
      .LOW_SINK_STRENGTH(lsn), .PEAK_DRIVE_CYC(peak), .DEAD_CYC(dead));
   gdcr_prot_model u_gdcr_prot_model (.MCLK(clk), .NRST(nrst), .trip(trip), .FAULT_CLEAR(fclr),
      .CYCLE_FAULT_CLEAR(cclr), .LATCHED_FAULTS(lat));
   ////////////////////////////////////////////////////////////
   function automatic int cyc(input int ns);
      return (ns + 7) / 8;
   endfunction
   task automatic chk(input [31:0] got, input [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (err_total == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // hold the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input [3:0] i, input [10:0] d, input [3:0] b, output [31:0] v);
      int k;
      @(posedge clk);
      adr <= {i, 2'b00};
      wdat <= {21'h0, d};
      be <= b;
      rd <= !w;
      wr <= w;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (wreq === 1'b0) break;
      end
      v = rdat;
      rd <= 0;
      wr <= 0;
      if (k == 20) begin
         chk(0, 1);
         give_verdict;
      end
   endtask
   task automatic wrr(input [3:0] i, input [10:0] d);
      bus(1, i, d, 4'h3, q);
   endtask
   task automatic rchk(input [3:0] i, input [10:0] e);
      bus(0, i, 11'h0, 4'h3, q);
      chk(q, {21'h0, e});
   endtask
   task automatic settle_trip;
      trip <= 1;
      @(posedge clk);
      trip <= 0;
      repeat (4) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////
   initial forever #4 clk = ~clk;
   initial begin
      repeat (100000) @(posedge clk);
      chk(0, 1);
      give_verdict;
   end
   initial begin
      void'($urandom(61332));
      repeat (2) @(posedge clk);
      nrst <= 1;
      rchk(2, 11'h000);
      rchk(3, 11'h3ff);
      rchk(4, 11'h7ff);
      rchk(5, 11'h159);
      chk({dead, peak, deg}, {6'd13, 9'd500, 10'd500});
      chk({rty, ocm, vds}, {19'd40, 2'h1, 4'h9});
      chk({hsp, hsn, lsp, lsn, mode}, {16'hffff, 2'h0});
      ex = 11'h159;
      for (n = 0; n < 12; n++) begin
         r = 11'($urandom);
         r[6:5] = n[1:0];
         ln = 2'($urandom);
         bus(1, 5, r, {2'b0, ln}, q);
         ex = {ln[1] ? r[10:8] : ex[10:8], ln[0] ? r[7:0] : ex[7:0]};
         rchk(5, ex);
         chk(dead, cyc(50 << ex[9:8]));
         chk(deg, cyc(2000 * (ex[5:4] + 1)));
         chk(rty, ex[10] ? 10 : 40);
         chk({ocm, vds}, {ex[7:6], ex[3:0]});
         wrr(3, {3'h3, r[7:0]});
         wrr(4, r);
         rchk(4, r);
         chk({hsp, hsn, lsp, lsn}, {r[7:0], r[7:0]});
         chk(peak, cyc(500 << r[9:8]));
         wrr(2, r);
         rchk(2, {r[10:1], 1'b0});
         chk({mode, pud, gfd, coast, free}, {r[6:5], r[9], r[8], r[2], r[4] && r[6:5] == 2'h2});
      end
      wrr(7, 11'h7ff);
      rchk(7, 11'h000);
      wrr(2, 11'h000);
      wrr(4, 11'h2a5);
      wrr(3, 11'h6a5);
      wrr(4, 11'h15a);
      rchk(4, 11'h2a5);
      wrr(5, ~ex);
      rchk(5, ex);
      wrr(2, 11'h7fe);
      rchk(2, 11'h006);
      chk(coast, 1);
      wrr(3, 11'h5ff);
      rchk(3, 11'h6a5);
      wrr(3, 11'h3a5);
      wrr(3, 11'h7a5);
      rchk(3, 11'h3a5);
      for (n = 0; n < 8; n++) begin
         dir <= n[0];
         brk <= n[0];
         wrr(2, {4'h0, n[2] ? 2'h2 : 2'h0, 1'b1, n[1], 1'b0, n[1], 1'b0});
         repeat (4) @(posedge clk);
         chk({sdir, bral, free}, {n[0] | n[1], n[2] & (n[0] | n[1]), n[2]});
      end
      wrr(2, 11'h000);
      settle_trip;
      chk({sflt, nflt}, 2'b10);
      wrr(2, 11'h001);
      overtemp_warning <= 1;
      repeat (3) @(posedge clk);
      chk({sflt, nflt, lat}, 3'b010);
      wrr(2, 11'h080);
      repeat (2) @(posedge clk);
      chk({sflt, nflt}, 2'b10);
      overtemp_warning <= 0;
      wrr(5, 11'h059);
      wrr(4, 11'h7ff);
      settle_trip;
      pwm <= ~pwm;
      repeat (5) @(posedge clk);
      chk(lat, 0);
      wrr(4, 11'h3ff);
      settle_trip;
      pwm <= ~pwm;
      repeat (5) @(posedge clk);
      chk(lat, 1);
      wrr(3, 11'h6ff);
      rchk(8, 11'h007);
      nrst <= 0;
      repeat (2) @(posedge clk);
      nrst <= 1;
      wrr(4, 11'h123);
      rchk(4, 11'h123);
      give_verdict;
   end
endmodule // gdcr_regs_tb
`default_nettype wire
